/* isrp_consts.svh */
// constants of the two-wire register port: address, pointer and timing
// included by the port module and the bench; holds definitions only
`ifndef ISRP_CONSTS_SVH
`define ISRP_CONSTS_SVH

// upper six bits of the 7-bit bus address; lsb comes from the select pin
`define ISRP_ADDR_HI 6'h34
// register pointer value that answers with the identity register
`define ISRP_ID_PTR 8'h00
// register pointer after reset
`define ISRP_PTR_RST 8'h00
// data bits per byte, also the bit counter value at the ack slot
`define ISRP_BYTE_BITS 4'h8
// fastest bus clock in kHz and the core clock in MHz
`define ISRP_SCL_MAX_KHZ 400
`define ISRP_CLK_MHZ 200
// shortest bus clock period in core cycles, rounded down
`define ISRP_SCL_PERIOD_CYC ((`ISRP_CLK_MHZ * 1000) / `ISRP_SCL_MAX_KHZ)
// core cycles the port may take to answer a bus clock edge
`define ISRP_ANSWER_CYC 2

`endif

/* isrp_pkg.sv */
// types of the two-wire register port: protocol states and the state record
// assumes isrp_consts.svh is on the include path
package isrp_pkg;

    // protocol position within a transfer
    typedef enum logic [2:0] {
        ISRP_IDLE,
        ISRP_ADDR,
        ISRP_ADDR_ACK,
        ISRP_RX,
        ISRP_RX_ACK,
        ISRP_TX,
        ISRP_TX_ACK,
        ISRP_IGNORE
    } isrp_state_type;

    // every flip-flop of the port module
    typedef struct packed {
        isrp_state_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic rw;
        logic ptr_phase;
        logic ack_ok;
        logic [7:0] ptr;
        logic busy;
        logic sda_oe;
        logic scl_oe;
        logic wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } isrp_regs_type;

endpackage

/* isrp_sync.sv */
// two-flop synchroniser with one more stage for edge detection
// assumes asynchronous inputs; q_o and q_d_o are safe to compare
`timescale 1ns/100ps
module isrp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous levels in
    input wire logic [W-1:0] d_i,
    // synchronised level and its value one cycle earlier
    output logic [W-1:0] q_o,
    output logic [W-1:0] q_d_o
);

    logic [W-1:0] meta_r;

    ////////////////////////////////////////////////////////////////////////
    // idle bus level is high, so reset to ones to avoid a false start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '1;
            q_o <= '1;
            q_d_o <= '1;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
            q_d_o <= q_o;
        end
    end

endmodule

/* isrp_port.sv */
// two-wire slave port giving a bus master access to the device registers
// assumes scl/sda/address select arrive asynchronously and a register
// file on clk_i that returns rd_data_i for register_pointer_o within one cycle
`timescale 1ns/100ps
`include "isrp_consts.svh"
module isrp_port
    import isrp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus pins, open drain: oe high pulls the line low
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // strap selecting the address lsb
    input wire logic address_select_pin_i,
    // register file side
    input wire logic stall_i,
    output logic [7:0] register_pointer_o,
    input wire logic [7:0] rd_data_i,
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    // bus status
    output logic busy_o
);

    isrp_regs_type r;
    isrp_regs_type r_nxt;
    logic [2:0] pin_s;
    logic [2:0] pin_d;
    logic scl_s;
    logic scl_d;
    logic sda_s;
    logic sda_d;
    logic sel_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [6:0] own_addr;
    logic [7:0] id_value;

    ////////////////////////////////////////////////////////////////////////
    // pins cross into the core clock; edges only from settled stages
    isrp_sync #(.W(3)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({scl_i, sda_i, address_select_pin_i}),
        .q_o(pin_s),
        .q_d_o(pin_d)
    );

    // bus events; sync latency of 3 cycles is tiny against 500 per bit
    assign {scl_s, sda_s, sel_s} = pin_s;
    assign scl_d = pin_d[2];
    assign sda_d = pin_d[1];
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;
    assign own_addr = {`ISRP_ADDR_HI, sel_s};
    assign id_value = {1'b0, own_addr};

    // byte to send: the identity register is answered here, rest from file
    function automatic logic [7:0] read_value(input logic [7:0] ptr, input logic [7:0] id,
                                              input logic [7:0] file);
        read_value = (ptr == `ISRP_ID_PTR) ? id : file;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // protocol engine: sample on scl rise, change sda on scl fall, release it on start or stop
    always_comb begin
        r_nxt = r;
        r_nxt.wr_en = 1'b0;
        if (start_ev) begin
            // a start or repeated start restarts address reception
            r_nxt.busy = 1'b1;
            r_nxt.st = ISRP_ADDR;
            r_nxt.cnt = 4'h0;
            r_nxt.sda_oe = 1'b0;
        end else if (stop_ev) begin
            r_nxt.busy = 1'b0;
            r_nxt.st = ISRP_IDLE;
            r_nxt.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                ISRP_IDLE, ISRP_IGNORE: begin
                    // released; a foreign transfer is ignored until start
                    r_nxt.sda_oe = 1'b0;
                end
                ISRP_ADDR, ISRP_RX: begin
                    if (scl_rise && r.cnt < `ISRP_BYTE_BITS) begin
                        r_nxt.sh = {r.sh[6:0], sda_s};
                        r_nxt.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == `ISRP_BYTE_BITS) begin
                        r_nxt.cnt = 4'h0;
                        if (r.st == ISRP_ADDR) begin
                            if (r.sh[7:1] == own_addr) begin
                                r_nxt.sda_oe = 1'b1;
                                r_nxt.rw = r.sh[0];
                                r_nxt.st = ISRP_ADDR_ACK;
                            end else begin
                                r_nxt.st = ISRP_IGNORE;
                            end
                        end else begin
                            // every received byte is acked, no length limit
                            r_nxt.sda_oe = 1'b1;
                            r_nxt.st = ISRP_RX_ACK;
                            if (r.ptr_phase) begin
                                r_nxt.ptr = r.sh;
                                r_nxt.ptr_phase = 1'b0;
                            end else begin
                                r_nxt.wr_en = 1'b1;
                                r_nxt.wr_addr = r.ptr;
                                r_nxt.wr_data = r.sh;
                                r_nxt.ptr = r.ptr + 8'h01;
                            end
                        end
                    end
                end
                ISRP_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (r.rw) begin
                            // read: first data bit goes out right away
                            r_nxt.tx = read_value(r.ptr, id_value, rd_data_i);
                            r_nxt.sda_oe = ~r_nxt.tx[7];
                            r_nxt.st = ISRP_TX;
                        end else begin
                            r_nxt.sda_oe = 1'b0;
                            r_nxt.ptr_phase = 1'b1;
                            r_nxt.st = ISRP_RX;
                        end
                    end
                end
                ISRP_RX_ACK: begin
                    if (scl_fall) begin
                        r_nxt.sda_oe = 1'b0;
                        r_nxt.st = ISRP_RX;
                    end
                end
                ISRP_TX: begin
                    if (scl_fall) begin
                        if (r.cnt == `ISRP_BYTE_BITS - 4'h1) begin
                            // release for the master's ack bit
                            r_nxt.sda_oe = 1'b0;
                            r_nxt.cnt = 4'h0;
                            r_nxt.st = ISRP_TX_ACK;
                        end else begin
                            r_nxt.tx = {r.tx[6:0], 1'b0};
                            r_nxt.sda_oe = ~r.tx[6];
                            r_nxt.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                ISRP_TX_ACK: begin
                    if (scl_rise) begin
                        r_nxt.ack_ok = ~sda_s;
                        if (!sda_s) begin
                            r_nxt.ptr = r.ptr + 8'h01;
                        end
                    end else if (scl_fall) begin
                        if (r.ack_ok) begin
                            r_nxt.tx = read_value(r.ptr, id_value, rd_data_i);
                            r_nxt.sda_oe = ~r_nxt.tx[7];
                            r_nxt.st = ISRP_TX;
                        end else begin
                            r_nxt.sda_oe = 1'b0;
                            r_nxt.st = ISRP_IGNORE;
                        end
                    end
                end
            endcase
        end
        // stretch only a clock the master already pulled low, never make one
        r_nxt.scl_oe = stall_i & r.busy & (r.st != ISRP_IGNORE)
                       & (r.scl_oe | ~scl_s);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{st: ISRP_IDLE, cnt: 4'h0, sh: 8'h00, tx: 8'hff, rw: 1'b0, ptr_phase: 1'b0,
                   ack_ok: 1'b0, ptr: `ISRP_PTR_RST, busy: 1'b0, sda_oe: 1'b0, scl_oe: 1'b0,
                   wr_en: 1'b0, wr_addr: 8'h00, wr_data: 8'h00};
        end else begin
            r <= r_nxt;
        end
    end

    // outputs straight from state; line levels are always low when enabled
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = r.scl_oe;
    assign sda_oe_o = r.sda_oe;
    assign register_pointer_o = r.ptr;
    assign wr_en_o = r.wr_en;
    assign wr_addr_o = r.wr_addr;
    assign wr_data_o = r.wr_data;
    assign busy_o = r.busy;

    ////////////////////////////////////////////////////////////////////////
    // checks on the driven behaviour
    localparam int SCL_PERIOD_CYC = `ISRP_SCL_PERIOD_CYC;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_STRETCH_ONLY_LOW: assert property ($rose(r.scl_oe) |-> !$past(scl_s))
        else $error("clock hold began while clock was high");
    AST_NEVER_MASTER: assert property (!r.busy |=> !r.scl_oe)
        else $error("clock driven outside a transfer");
    AST_START_TO_ADDR: assert property (start_ev |=> r.st == ISRP_ADDR && r.busy && r.cnt == 4'h0)
        else $error("start not taken into address reception");
    AST_STOP_TO_IDLE: assert property (stop_ev && !start_ev |=> !r.busy && !r.sda_oe)
        else $error("stop left bus busy or data driven");
    AST_RESTART_BUSY: assert property (r.busy && start_ev |=> r.busy ##0 r.st == ISRP_ADDR)
        else $error("repeated start dropped busy");
    AST_ADDR_MATCH_ACK: assert property (r.st == ISRP_ADDR && scl_fall && !start_ev && !stop_ev
        && r.cnt == `ISRP_BYTE_BITS && r.sh[7:1] == own_addr |=> r.sda_oe && r.st == ISRP_ADDR_ACK)
        else $error("own address not acknowledged");
    AST_ACK_HELD: assert property (r.st == ISRP_RX_ACK && !scl_fall && !start_ev && !stop_ev
        |=> r.sda_oe)
        else $error("ack released before clock fell");
    AST_MISMATCH_QUIET: assert property (r.st == ISRP_IGNORE |-> !r.sda_oe)
        else $error("data driven during foreign transfer");
    AST_SDA_ON_LOW_CLOCK: assert property ($changed(r.sda_oe) |-> $past(scl_fall || start_ev || stop_ev))
        else $error("data changed away from a clock fall");
    AST_ANSWER_FAST: assert property (scl_fall && r.st == ISRP_RX_ACK && !start_ev && !stop_ev
        |=> !r.sda_oe && SCL_PERIOD_CYC > `ISRP_ANSWER_CYC)
        else $error("ack release late for the bus rate");
    AST_BYTE_LEN: assert property (r.cnt <= `ISRP_BYTE_BITS)
        else $error("bit counter ran past a byte");
    AST_PTR_LATCH: assert property (r.st == ISRP_RX && r.ptr_phase && scl_fall && !start_ev && !stop_ev
        && r.cnt == `ISRP_BYTE_BITS |=> r.ptr == $past(r.sh) && r.sda_oe && !r.wr_en)
        else $error("pointer byte not latched");
    AST_WRITE_ADVANCE: assert property (r.wr_en |-> r.ptr == r.wr_addr + 8'h01 ##1 !r.wr_en)
        else $error("write did not advance pointer or strobe too long");
    AST_READ_ADVANCE: assert property (r.st == ISRP_TX_ACK && scl_rise && !sda_s && !start_ev && !stop_ev
        |=> r.ptr == $past(r.ptr) + 8'h01)
        else $error("pointer not advanced on read ack");
    AST_NACK_RELEASE: assert property (r.st == ISRP_TX_ACK && !r.ack_ok && scl_fall && !start_ev
        && !stop_ev |=> !r.sda_oe ##1 !r.sda_oe)
        else $error("data still driven after nack");
    AST_ID_READ: assert property (r.st == ISRP_ADDR_ACK && r.rw && scl_fall && !start_ev && !stop_ev
        && r.ptr == `ISRP_ID_PTR |=> r.tx == id_value && r.st == ISRP_TX)
        else $error("identity read returned wrong byte");

endmodule

/* isrp_master_model.sv */
// bus master model for the two-wire register port: start, stop, bytes
// assumes the bench resolves open-drain wires with pull-ups to high
`timescale 1ns/100ps
module isrp_master_model #(
    parameter int QTR_NS = 20
) (
    // resolved wire levels
    input wire logic scl_i,
    input wire logic sda_i,
    // pull-down enables, high pulls the wire low
    output logic scl_oe_o,
    output logic sda_oe_o,
    // slave held the clock past the bound
    output logic stuck_o
);
    // bus idle: both lines released
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        stuck_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // release the clock and wait, bounded, for a stretching slave
    task automatic clk_high();
        int n;
        n = 0;
        scl_oe_o = 1'b0;
        while (scl_i !== 1'b1 && n < 4000) begin
            #5;
            n++;
        end
        if (n >= 4000) stuck_o = 1'b1;
    endtask

    // start from idle, or repeated start from a low clock
    task automatic start();
        if (scl_oe_o) begin
            #QTR_NS sda_oe_o = 1'b0;
            #QTR_NS clk_high();
            #QTR_NS;
        end
        sda_oe_o = 1'b1;
        #QTR_NS scl_oe_o = 1'b1;
    endtask

    // one bit: data moves only in the low phase, sampled mid-high
    task automatic bit_xfer(input logic tx, output logic rx);
        #QTR_NS sda_oe_o = ~tx;
        #QTR_NS clk_high();
        #QTR_NS rx = sda_i;
        #QTR_NS scl_oe_o = 1'b1;
    endtask

    // stop, then some bus free time
    task automatic stop();
        #QTR_NS sda_oe_o = 1'b1;
        #QTR_NS clk_high();
        #QTR_NS sda_oe_o = 1'b0;
        #(4 * QTR_NS);
    endtask

    // byte out msb first, data released for the slave's ack
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    // byte in, then ack or, on the last byte, nack
    task automatic byte_in(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(~ack, r);
    endtask
endmodule

/* isrp_port_tb.sv */
// self-checking bench for the two-wire register port
// assumes isrp_port, isrp_pkg and isrp_master_model are compiled first
`timescale 1ns/100ps
`include "isrp_consts.svh"
module isrp_port_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sel = 1'b0;
    logic stall = 1'b0;
    logic stall_en = 1'b0;
    logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, stuck, wr_en, busy;
    logic [7:0] ptr, wr_addr, wr_data, rd_data;
    logic scl_lvl, sda_lvl;
    logic [7:0] mem [256];
    logic [7:0] mem_exp [256];
    logic [31:0] rnd_state = 32'h00013f81;
    logic [31:0] rs;
    wire scl_w = ~(scl_oe | m_scl_oe);
    wire sda_w = ~(sda_oe | m_sda_oe);
    int bad_count = 0;
    int n_checks = 0;
    int n_wr = 0;
    int n_stretch = 0;
    int low_cnt = 0;

    always #2.5 clk_i = ~clk_i;

    isrp_port i_dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .scl_i(scl_w), .scl_o(scl_lvl), .scl_oe_o(scl_oe),
        .sda_i(sda_w), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
        .address_select_pin_i(sel), .stall_i(stall),
        .register_pointer_o(ptr), .rd_data_i(rd_data),
        .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .busy_o(busy)
    );
    isrp_master_model i_mst (
        .scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe), .stuck_o(stuck)
    );

    ////////////////////////////////////////////////////////////////////////
    // register file: combinational read, written on the pulse
    assign rd_data = mem[ptr];
    always @(posedge clk_i) begin
        if (wr_en) mem[wr_addr] <= wr_data;
        if (wr_en) n_wr <= n_wr + 1;
        if (scl_oe) n_stretch <= n_stretch + 1;
        low_cnt <= m_scl_oe ? low_cnt + 1 : 0;
    end

    // stall may rise only early in a master low phase, so it never clips a high phase
    always @(posedge clk_i) begin
        #1;
        rs = xs();
        if (!stall_en || rs[3:0] < 4'h4) stall = 1'b0;
        else if (m_scl_oe && low_cnt < 3 && rs[4]) stall = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rnd_state = rnd_state ^ (rnd_state << 13);
        rnd_state = rnd_state ^ (rnd_state >> 17);
        rnd_state = rnd_state ^ (rnd_state << 5);
        return rnd_state;
    endfunction

    // expected read byte: identity at its pointer, else the file
    function automatic logic [7:0] exp_rd(input logic [7:0] p);
        return (p == `ISRP_ID_PTR) ? {1'b0, `ISRP_ADDR_HI, sel} : mem_exp[p];
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // address byte then pointer byte, both acked
    task automatic head(input logic [7:0] p);
        logic a;
        i_mst.start();
        i_mst.byte_out({`ISRP_ADDR_HI, sel, 1'b0}, a);
        check({7'h00, a}, 8'h01, "address ack");
        check({7'h00, busy}, 8'h01, "busy in transfer");
        i_mst.byte_out(p, a);
        check({7'h00, a}, 8'h01, "pointer ack");
    endtask

    task automatic finish_xfer();
        i_mst.stop();
        check({7'h00, busy}, 8'h00, "busy after stop");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // burst write of n random bytes from pointer p
    task automatic do_write(input logic [7:0] p, input int n);
        logic a;
        logic [31:0] x;
        head(p);
        for (int i = 0; i < n; i++) begin
            x = xs();
            i_mst.byte_out(x[7:0], a);
            mem_exp[p + i[7:0]] = x[7:0];
            check({7'h00, a}, 8'h01, "data ack");
        end
        #30 check(ptr, p + n[7:0], "pointer after write");
        finish_xfer();
        for (int i = 0; i < n; i++) begin
            check(mem[p + i[7:0]], mem_exp[p + i[7:0]], "stored byte");
        end
    endtask

    // pointer write, repeated start, burst read of n bytes
    task automatic do_read(input logic [7:0] p, input int n);
        logic a;
        logic [7:0] d;
        head(p);
        i_mst.start();
        #30 check({7'h00, busy}, 8'h01, "busy over repeated start");
        i_mst.byte_out({`ISRP_ADDR_HI, sel, 1'b1}, a);
        check({7'h00, a}, 8'h01, "read address ack");
        for (int i = 0; i < n; i++) begin
            i_mst.byte_in(i != n - 1, d);
            check(d, exp_rd(p + i[7:0]), "read byte");
        end
        #30 check({7'h00, sda_oe}, 8'h00, "data released after nack");
        check(ptr, p + n[7:0] - 8'h01, "pointer after read");
        finish_xfer();
    endtask

    // foreign address: no ack, no write, rest ignored
    task automatic wrong_addr(input logic [6:0] ad);
        logic a;
        int w;
        w = n_wr;
        i_mst.start();
        i_mst.byte_out({ad, 1'b0}, a);
        check({7'h00, a}, 8'h00, "foreign address ack");
        i_mst.byte_out(8'h00, a);
        check({7'h00, a}, 8'h00, "ignored byte ack");
        finish_xfer();
        check(8'(n_wr - w), 8'h00, "writes while ignored");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // file contents known before any access
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 7 + 3);
            mem_exp[i] = 8'(i * 7 + 3);
        end
    end

    // main sequence: reset, both address strap levels, plain and stalled bursts
    initial begin
        logic [31:0] x;
        repeat (6) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1 check(ptr, `ISRP_PTR_RST, "pointer after reset");
        check({4'h0, busy, wr_en, scl_oe, sda_oe}, 8'h00, "outputs after reset");
        check({6'h00, scl_lvl, sda_lvl}, 8'h00, "open drain levels");
        for (int s = 0; s < 2; s++) begin
            sel = s[0];
            #100;
            wrong_addr({`ISRP_ADDR_HI, ~sel});
            wrong_addr({~`ISRP_ADDR_HI, sel});
            $display("foreign address test done, strap %0d", s);
            for (int k = 0; k < 4; k++) begin
                stall_en = k[0];
                x = xs();
                do_write(x[7:0], k + 1);
                do_read((k == 0) ? `ISRP_ID_PTR : x[7:0], k + 2);
                $display("write and read test %0d done, strap %0d", k, s);
            end
        end
        check({7'h00, n_stretch > 0}, 8'h01, "clock stretched");
        tally_and_finish();
    end

    // hang guards
    always @(posedge stuck) begin
        bad_count++;
        tally_and_finish();
    end
    initial begin
        #400000;
        bad_count++;
        tally_and_finish();
    end
endmodule
